// File: core/wc_cfg.svh
// Offsets, input positions, reset values and timing of the weld input logic.
// Included by the package; holds definitions only.
`ifndef WC_CFG_SVH
`define WC_CFG_SVH
// Timing
`define WC_CLK_KHZ  100000
`define WC_HOLD_MS  5
`define WC_DELAY_S  60
`define WC_FILT_W   20
`define WC_MS_W     17
`define WC_DLY_W    33
// Input function positions
`define WC_NIN      31
`define WC_I_ACT    0
`define WC_I_TRIG   1
`define WC_I_HOME   2
`define WC_I_ABORT  3
`define WC_I_GND    4
`define WC_I_ILK    5
`define WC_I_PART   6
`define WC_I_RF     7
`define WC_I_RFOK   11
`define WC_I_CABLE  12
`define WC_I_LOCK   13
`define WC_I_AMP    14
`define WC_I_SCAN   15
`define WC_I_ARST   16
`define WC_I_SEEK   17
`define WC_I_HOLD   18
`define WC_I_XST    19
`define WC_I_TEST   20
`define WC_I_PLOAD  21
`define WC_I_FCTR   22
`define WC_I_PSEL   23
`define WC_I_INH    29
`define WC_I_BEGIN  30
// Register byte offsets
`define WC_A_CTRL   8'h00
`define WC_A_POL    8'h04
`define WC_A_SCRUB  8'h08
`define WC_A_CUT    8'h0c
`define WC_A_STAT   8'h10
`define WC_A_LVL    8'h14
// Control register bits
`define WC_C_MAN    0
`define WC_C_PART   1
`define WC_C_CABLE  2
`define WC_C_AMPX   3
`define WC_C_RFBIN  4
`define WC_C_ABRST  5
`define WC_C_INDET  6
// Reset values
`define WC_CTRL_RST  8'h01
`define WC_SCRUB_RST 16'h0064
`define WC_CUT_RST   16'h03e8
`endif

// File: core/wc_pkg.sv
// Types of the weld input logic: bus carriers, outputs, state.
// Assumes wc_cfg.svh is on the include path.
package wc_pkg;
	`include "wc_cfg.svh"
	typedef enum logic [2:0] {
		st_idle = 3'b000, st_arm  = 3'b001, st_weld = 3'b011,
		st_done = 3'b010, st_seek = 3'b110, st_scan = 3'b111,
		st_test = 3'b101, st_lock = 3'b100
	} wc_state_t;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wc_wb_req_t;
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wc_wb_rsp_t;
	typedef struct packed {
		logic       sonics;
		logic       amp2;
		logic       seek;
		logic       ready;
		logic       busy;
		logic       home;
		logic       alarm;
		logic       lock;
		logic       rf_ok;
		logic       preset_stb;
		logic       center_stb;
		logic [3:0] relay;
		logic [5:0] preset;
	} wc_out_t;
	typedef struct packed {
		logic [`WC_NIN-1:0]                 s1;
		logic [`WC_NIN-1:0]                 s2;
		logic [`WC_NIN-1:0]                 s3;
		logic [`WC_NIN-1:0]                 lvl;
		logic [`WC_NIN-1:0][`WC_FILT_W-1:0] fcnt;
		logic [`WC_NIN-1:0]                 fn_q;
		logic [`WC_NIN-1:0]                 pol;
		logic [7:0]                         ctrl;
		logic [15:0]                        scrub;
		logic [15:0]                        cutoff;
		wc_state_t                          st;
		logic [`WC_FILT_W-1:0]              boot_cnt;
		logic                               booted;
		logic                               act_en;
		logic                               alarm;
		logic                               need_cyc;
		logic [`WC_DLY_W-1:0]               dcnt;
		logic [`WC_MS_W-1:0]                ms_pre;
		logic                               scrub_run;
		logic [15:0]                        scrub_cnt;
		logic [15:0]                        cut_cnt;
		wc_wb_rsp_t                         wb;
		wc_out_t                            o;
	} wc_st_t;
endpackage : wc_pkg

// File: core/wc_input_ctrl.sv
// Weld cycle control driven by discrete automation inputs, with a
// classic Wishbone register slave. Pins are asynchronous to clk_i.
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`include "wc_cfg.svh"
module wc_input_ctrl #(
	parameter int unsigned     FILT_CYC  = `WC_HOLD_MS * `WC_CLK_KHZ,
	parameter int unsigned     MS_CYC    = `WC_CLK_KHZ,
	parameter longint unsigned DELAY_CYC = 64'(`WC_DELAY_S) * 1000 *
		`WC_CLK_KHZ
) (
	// Clock, reset, enable
	input  logic               clk_i,
	input  logic               rst_i,
	input  logic               ce_i,
	// Discrete input pins
	input  logic [`WC_NIN-1:0] pins_i,
	// Register bus
	input  wc_pkg::wc_wb_req_t wb_i,
	output wc_pkg::wc_wb_rsp_t wb_o,
	// Weld control
	output wc_pkg::wc_out_t    ctl_o
);
	import wc_pkg::*;

	localparam logic [`WC_FILT_W-1:0] FILT_M1  = `WC_FILT_W'(FILT_CYC - 1);
	localparam logic [`WC_FILT_W-1:0] BOOT_END = `WC_FILT_W'(FILT_CYC + 3);
	localparam logic [`WC_MS_W-1:0]   MS_M1    = `WC_MS_W'(MS_CYC - 1);
	localparam logic [`WC_DLY_W-1:0]  DLY_M1   = `WC_DLY_W'(DELAY_CYC - 1);

	wc_st_t                              r;
	wc_st_t                              next_r;
	logic   [`WC_NIN-1:0]                lvl_n;
	logic   [`WC_NIN-1:0][`WC_FILT_W-1:0] fcnt_n;
	logic   [`WC_NIN-1:0]                fn;
	logic   [`WC_NIN-1:0]                rise;
	logic                                tick;
	logic                                cab_bad;
	logic                                son_ok;
	logic                                start_ok;
	logic                                start_rq;
	logic                                start_hold;
	logic                                scrub_exp;
	logic                                cut_hit;
	logic                                weld_end;
	logic                                acc;
	logic   [31:0]                       wdat;
	logic   [31:0]                       rdat;

	// Byte-lane merge of a write into an old register value
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = dat[8*b +: 8];
			end
		end
		return res;
	endfunction : merge

	// Per input: a change is taken once s2 and s3 agree for FILT_CYC
	for (genvar i = 0; i < `WC_NIN; i++) begin : g_filt
		logic chg;
		assign chg = (r.s2[i] == r.s3[i]) && (r.s3[i] != r.lvl[i]);
		assign lvl_n[i] = (chg && r.fcnt[i] == FILT_M1) ? r.s3[i]
			: r.lvl[i];
		assign fcnt_n[i] = (chg && r.fcnt[i] != FILT_M1)
			? r.fcnt[i] + 1'b1 : '0;
	end

	// Polarity, manual-mode gate and derived conditions
	always_comb begin
		fn = (r.lvl ^ r.pol) & {`WC_NIN{r.ctrl[`WC_C_MAN]}};
		rise = fn & ~r.fn_q;
		tick = (r.ms_pre == MS_M1);
		cab_bad = r.ctrl[`WC_C_CABLE] && !fn[`WC_I_CABLE];
		son_ok = !cab_bad && !fn[`WC_I_INH];
		start_hold = fn[`WC_I_XST] || fn[`WC_I_BEGIN];
		start_rq = rise[`WC_I_XST] || rise[`WC_I_BEGIN];
		start_ok = r.booted && !fn[`WC_I_ABORT] && !r.alarm &&
			!r.need_cyc && (!r.act_en || fn[`WC_I_ILK]) &&
			(!r.act_en || !r.ctrl[`WC_C_PART] ||
			fn[`WC_I_PART]);
		scrub_exp = r.scrub_run && (r.scrub_cnt >= r.scrub);
		cut_hit = (r.cutoff != 16'h0000) && (r.cut_cnt >= r.cutoff);
		weld_end = cab_bad || scrub_exp || cut_hit ||
			(!(r.ctrl[`WC_C_INDET] && fn[`WC_I_INH]) &&
			!start_hold);
		acc = wb_i.cyc && wb_i.stb && !r.wb.ack;
	end

	// Register read mux
	always_comb begin
		case (wb_i.adr)
			`WC_A_CTRL:  rdat = {24'h00_0000, r.ctrl};
			`WC_A_POL:   rdat = {1'b0, r.pol};
			`WC_A_SCRUB: rdat = {16'h0000, r.scrub};
			`WC_A_CUT:   rdat = {16'h0000, r.cutoff};
			`WC_A_STAT:  rdat = {9'h000, r.st, r.booted, r.act_en,
				r.alarm, r.need_cyc, r.o[15:0]};
			`WC_A_LVL:   rdat = {1'b0, fn};
			default:     rdat = 32'h0000_0000;
		endcase
	end

	// Next state of the whole block
	always_comb begin
		next_r = r;
		wdat = 32'h0000_0000;
		next_r.s1 = pins_i;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		next_r.lvl = lvl_n;
		next_r.fcnt = fcnt_n;
		next_r.fn_q = fn;
		next_r.ms_pre = tick ? '0 : r.ms_pre + 1'b1;
		// Actuator present sampled once the filter has settled
		if (!r.booted) begin
			next_r.boot_cnt = r.boot_cnt + 1'b1;
			if (r.boot_cnt == BOOT_END) begin
				next_r.booted = 1'b1;
				next_r.act_en = fn[`WC_I_ACT];
			end
		end
		// Bus slave, one wait state, writes refused under panel lock
		next_r.wb.ack = acc;
		next_r.wb.dat = acc ? rdat : 32'h0000_0000;
		// Write lands at the edge that samples ack high, request still held
		if (r.wb.ack && wb_i.cyc && wb_i.stb && wb_i.we &&
			!fn[`WC_I_LOCK]) begin
			case (wb_i.adr)
				`WC_A_CTRL: begin
					wdat = merge({24'h00_0000, r.ctrl}, wb_i.dat, wb_i.sel);
					next_r.ctrl = wdat[7:0];
				end
				`WC_A_POL: begin
					wdat = merge({1'b0, r.pol}, wb_i.dat, wb_i.sel);
					next_r.pol = wdat[`WC_NIN-1:0];
				end
				`WC_A_SCRUB: begin
					wdat = merge({16'h0000, r.scrub}, wb_i.dat, wb_i.sel);
					next_r.scrub = wdat[15:0];
				end
				`WC_A_CUT: begin
					wdat = merge({16'h0000, r.cutoff}, wb_i.dat, wb_i.sel);
					next_r.cutoff = wdat[15:0];
				end
				default: begin
					wdat = 32'h0000_0000;
				end
			endcase
		end
		// Inputs must all drop after a hold-off abort
		if (r.need_cyc && fn == '0) begin
			next_r.need_cyc = 1'b0;
		end
		// Weld cycle sequence
		case (r.st)
			st_idle: begin
				next_r.dcnt = '0;
				next_r.cut_cnt = 16'h0000;
				next_r.scrub_run = 1'b0;
				if (start_rq && start_ok) begin
					next_r.st = st_arm;
				end else if (r.booted && !r.alarm && !r.need_cyc) begin
					if (rise[`WC_I_SCAN]) begin
						next_r.st = st_scan;
					end else if (rise[`WC_I_TEST]) begin
						next_r.st = st_test;
					end else if (rise[`WC_I_SEEK]) begin
						next_r.st = st_seek;
					end
				end
			end
			st_arm: begin
				if (fn[`WC_I_HOLD]) begin
					next_r.dcnt = r.dcnt + 1'b1;
					if (r.dcnt == DLY_M1) begin
						next_r.st = st_idle;
						next_r.need_cyc = 1'b1;
					end
				end else if (!r.act_en || fn[`WC_I_TRIG]) begin
					next_r.st = st_weld;
				end else begin
					next_r.dcnt = '0;
				end
			end
			st_weld: begin
				if (tick) begin
					next_r.cut_cnt = r.cut_cnt + 1'b1;
					next_r.scrub_cnt = r.scrub_cnt + 1'b1;
				end
				if (rise[`WC_I_GND] && !r.scrub_run) begin
					next_r.scrub_run = 1'b1;
					next_r.scrub_cnt = 16'h0000;
				end
				if (weld_end) begin
					next_r.st = st_done;
				end
			end
			st_done: begin
				if (!start_hold) begin
					next_r.st = st_idle;
				end
			end
			st_seek: begin
				if (!fn[`WC_I_SEEK]) begin
					next_r.st = st_idle;
				end
			end
			st_scan: begin
				if (!fn[`WC_I_SCAN]) begin
					next_r.st = st_idle;
				end
			end
			st_test: begin
				if (!fn[`WC_I_TEST]) begin
					next_r.st = st_idle;
				end
			end
			st_lock: begin
				next_r.st = st_lock;
			end
			default: begin
				next_r.st = st_idle;
			end
		endcase
		// Abort ends any activity, optionally latching an alarm
		if (fn[`WC_I_ABORT] && r.st != st_idle && r.st != st_lock) begin
			next_r.st = r.ctrl[`WC_C_ABRST] ? st_lock : st_idle;
			next_r.alarm = r.ctrl[`WC_C_ABRST];
		end
		// Alarm reset clears latched alarm and hold-off lockout
		if (rise[`WC_I_ARST]) begin
			next_r.alarm = 1'b0;
			next_r.need_cyc = 1'b0;
			if (next_r.st == st_lock) begin
				next_r.st = st_idle;
			end
		end
		// Registered outputs
		next_r.o.sonics = son_ok && !scrub_exp &&
			((next_r.st == st_weld) || (next_r.st == st_seek) ||
			(next_r.st == st_scan) || (next_r.st == st_test));
		next_r.o.seek = (next_r.st == st_seek);
		next_r.o.amp2 = (next_r.st == st_weld) &&
			r.ctrl[`WC_C_AMPX] && fn[`WC_I_AMP];
		next_r.o.ready = (next_r.st == st_idle) && r.booted &&
			!next_r.alarm && !next_r.need_cyc;
		next_r.o.busy = (next_r.st != st_idle) && (next_r.st != st_lock);
		next_r.o.home = r.act_en && fn[`WC_I_HOME];
		next_r.o.alarm = next_r.alarm;
		next_r.o.lock = fn[`WC_I_LOCK];
		next_r.o.rf_ok = fn[`WC_I_RFOK];
		if (r.ctrl[`WC_C_RFBIN]) begin
			next_r.o.relay = fn[`WC_I_RF +: 4];
		end else begin
			next_r.o.relay = 4'h0;
			for (int k = 3; k >= 0; k--) begin
				if (fn[`WC_I_RF + k]) begin
					next_r.o.relay = 4'(k + 1);
				end
			end
		end
		next_r.o.preset_stb = rise[`WC_I_PLOAD];
		if (rise[`WC_I_PLOAD]) begin
			next_r.o.preset = fn[`WC_I_PSEL +: 6];
		end
		next_r.o.center_stb = rise[`WC_I_FCTR];
	end

	// State register, frozen while ce_i is low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.ctrl <= `WC_CTRL_RST;
			r.scrub <= `WC_SCRUB_RST;
			r.cutoff <= `WC_CUT_RST;
		end else if (ce_i) begin
			r <= next_r;
		end
	end

	assign wb_o = r.wb;
	assign ctl_o = r.o;

	// Checks of the weld sequence, input gating, preset load and bus ack
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i || !ce_i);

	a_abort_ends_cycle: assert property (
		fn[`WC_I_ABORT] && r.st != st_idle && r.st != st_lock
		|=> (r.st == st_idle || r.st == st_lock) && !ctl_o.sonics)
		else $error("abort did not end the cycle");
	a_abort_refuses: assert property (
		fn[`WC_I_ABORT] && r.st == st_idle |=> r.st != st_arm)
		else $error("start taken during abort");
	a_interlock_gate: assert property (
		r.st == st_idle && r.act_en && !fn[`WC_I_ILK] |=> r.st != st_arm)
		else $error("start taken without interlock");
	a_part_gate: assert property (
		r.st == st_idle && r.act_en && r.ctrl[`WC_C_PART] &&
		!fn[`WC_I_PART] |=> r.st != st_arm)
		else $error("start taken without part present");
	a_cable_stops: assert property (
		cab_bad |=> !ctl_o.sonics)
		else $error("sonics on without cable");
	a_inhibit_blocks: assert property (
		fn[`WC_I_INH] |=> !ctl_o.sonics)
		else $error("sonics on while inhibited");
	a_holdoff_waits: assert property (
		r.st == st_arm && fn[`WC_I_HOLD] |=> r.st != st_weld)
		else $error("weld began during hold off");
	a_manual_gate: assert property (
		!r.ctrl[`WC_C_MAN] |-> fn == '0)
		else $error("input seen outside manual mode");
	a_preset_load: assert property (
		rise[`WC_I_PLOAD] |=> ctl_o.preset_stb &&
		ctl_o.preset == $past(fn[`WC_I_PSEL +: 6]))
		else $error("preset code not loaded");
	a_reset_clears: assert property (
		rise[`WC_I_ARST] |=> !ctl_o.alarm ##1 !r.alarm)
		else $error("alarm reset ignored");
	a_bus_ack: assert property (
		acc |=> wb_o.ack ##1 !wb_o.ack)
		else $error("ack not a single cycle");

	c_weld: cover property (r.st == st_arm ##1 r.st == st_weld);
	c_abort_lock: cover property (r.st == st_weld ##1 r.st == st_lock);
	c_seek: cover property (r.st == st_seek && ctl_o.sonics);
	c_preset: cover property (ctl_o.preset_stb);
endmodule : wc_input_ctrl

// File: testbench/wc_plc_model.sv
// Automation controller model that drives the discrete input pins.
// Assumes the weld input logic samples pins_o against clk_i.
`timescale 1ns/1ps
module wc_plc_model #(
	parameter int HOLD = 14
) (
	// Clock
	input  logic        clk_i,
	// Discrete pins
	output logic [30:0] pins_o
);
	// Actuator present from power up, every other line idle
	initial pins_o = 31'h0000_0001;

	// Set a field of lines, then keep it for the minimum hold time
	task automatic drive(input int idx, input int w, input logic [5:0] v);
		for (int i = 0; i < w; i++) begin
			pins_o[idx+i] <= v[i];
		end
		repeat (HOLD) @(posedge clk_i);
	endtask : drive

	// Pulse shorter than the filter, only when the bench asks for it
	task automatic glitch(input int idx, input int n);
		pins_o[idx] <= 1'b1;
		repeat (n) @(posedge clk_i);
		pins_o[idx] <= 1'b0;
		repeat (HOLD) @(posedge clk_i);
	endtask : glitch
endmodule : wc_plc_model

// File: testbench/tb.sv
// Bench for the weld input logic: bus tasks plus pin scenarios.
// Assumes wc_cfg.svh on the include path and a shortened filter.
`timescale 1ns/1ps
`include "wc_cfg.svh"
`define CHK(g, e) chk(32'(g), 32'(e))
module tb;
	import wc_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [30:0] pins;
	wc_wb_req_t  wb    = '0;
	wc_wb_rsp_t  rsp;
	wc_out_t     ctl;
	logic [31:0] rd;
	int          err_count = 0;
	int          n_tests   = 0;
	int          n_ctr     = 0;
	int          n_pld     = 0;
	logic        ce        = 1'b1;
	logic [7:0]  ra [5] = '{`WC_A_CTRL, `WC_A_POL, `WC_A_SCRUB, `WC_A_CUT,
		8'h20};
	logic [31:0] rv [5] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0064,
		32'h0000_03e8, 32'h0000_0000};
	int          sidx [3] = '{`WC_I_SEEK, `WC_I_SCAN, `WC_I_TEST};

	// Clock at 100 MHz
	always #5 clk_i = ~clk_i;

	// Count recentre and preset-load pulses
	always @(posedge clk_i) begin
		if (ctl.center_stb === 1'b1) n_ctr++;
		if (ctl.preset_stb === 1'b1) n_pld++;
	end

	wc_plc_model #(.HOLD(14)) plc (.clk_i(clk_i), .pins_o(pins));

	wc_input_ctrl #(.FILT_CYC(4), .MS_CYC(10), .DELAY_CYC(50)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .pins_i(pins),
		.wb_i(wb), .wb_o(rsp), .ctl_o(ctl));

	// Print counts and verdict, then stop
	task automatic conclude();
		$display("checks %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude

	// Compare one value
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	// One classic Wishbone cycle, entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
		do begin
			@(posedge clk_i);
			n++;
		end while (rsp.ack !== 1'b1 && n < 32);
		q = rsp.dat;
		wb <= '0;
		@(posedge clk_i);
		if (n >= 32) begin
			err_count++;
			conclude();
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, rd);
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, '0, rd);
		`CHK(rd, e);
	endtask : rdchk

	// Main sequence
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ra[i]) begin
			rdchk(ra[i], rv[i]);
		end
		repeat (10) @(posedge clk_i);
		bus(1'b0, `WC_A_STAT, '0, rd);
		`CHK(rd[19:18], 2'b11);
		wr(`WC_A_CTRL, 32'h0000_0039);
		// Start refused while the interlock is open
		plc.drive(`WC_I_XST, 1, 6'h01);
		`CHK(ctl.busy, 1'b0);
		plc.drive(`WC_I_XST, 1, 6'h00);
		plc.drive(`WC_I_ILK, 1, 6'h01);
		plc.drive(`WC_I_TRIG, 1, 6'h01);
		`CHK(ctl.ready, 1'b1);
		plc.drive(`WC_I_XST, 1, 6'h01);
		`CHK({ctl.sonics, ctl.busy, ctl.ready}, 3'b110);
		plc.drive(`WC_I_AMP, 1, 6'h01);
		`CHK(ctl.amp2, 1'b1);
		plc.drive(`WC_I_AMP, 1, 6'h00);
		`CHK(ctl.amp2, 1'b0);
		// Abort mid weld, restart while still held, then alarm reset
		plc.drive(`WC_I_ABORT, 1, 6'h01);
		`CHK({ctl.sonics, ctl.alarm}, 2'b01);
		plc.drive(`WC_I_XST, 1, 6'h00);
		plc.drive(`WC_I_XST, 1, 6'h01);
		`CHK(ctl.busy, 1'b0);
		plc.drive(`WC_I_XST, 1, 6'h00);
		plc.drive(`WC_I_ABORT, 1, 6'h00);
		`CHK(ctl.alarm, 1'b1);
		plc.drive(`WC_I_ARST, 1, 6'h01);
		`CHK({ctl.alarm, ctl.ready}, 2'b01);
		plc.drive(`WC_I_ARST, 1, 6'h00);
		// Hold-off kept past the delay limit drops back to idle
		plc.drive(`WC_I_HOLD, 1, 6'h01);
		plc.drive(`WC_I_XST, 1, 6'h01);
		`CHK({ctl.sonics, ctl.busy}, 2'b01);
		repeat (60) @(posedge clk_i);
		bus(1'b0, `WC_A_STAT, '0, rd);
		`CHK({rd[22:20], rd[16], ctl.sonics}, 5'b00010);
		plc.drive(`WC_I_XST, 1, 6'h00);
		plc.drive(`WC_I_HOLD, 1, 6'h00);
		plc.drive(`WC_I_ARST, 1, 6'h01);
		plc.drive(`WC_I_ARST, 1, 6'h00);
		bus(1'b0, `WC_A_STAT, '0, rd);
		`CHK(rd[16], 1'b0);
		// Cable loss stops a running weld
		wr(`WC_A_CTRL, 32'h0000_003d);
		plc.drive(`WC_I_CABLE, 1, 6'h01);
		plc.drive(`WC_I_XST, 1, 6'h01);
		`CHK(ctl.sonics, 1'b1);
		plc.drive(`WC_I_CABLE, 1, 6'h00);
		`CHK(ctl.sonics, 1'b0);
		plc.drive(`WC_I_XST, 1, 6'h00);
		// Part present enabled: start refused until the part is seen
		wr(`WC_A_CTRL, 32'h0000_003b);
		plc.drive(`WC_I_XST, 1, 6'h01);
		`CHK(ctl.busy, 1'b0);
		plc.drive(`WC_I_XST, 1, 6'h00);
		plc.drive(`WC_I_PART, 1, 6'h01);
		// Scrub of 3 ms, 30 cycles with the shortened millisecond
		wr(`WC_A_SCRUB, 32'h0000_0003);
		plc.drive(`WC_I_XST, 1, 6'h01);
		plc.drive(`WC_I_GND, 1, 6'h01);
		`CHK(ctl.sonics, 1'b1);
		repeat (40) @(posedge clk_i);
		`CHK(ctl.sonics, 1'b0);
		plc.drive(`WC_I_XST, 1, 6'h00);
		plc.drive(`WC_I_GND, 1, 6'h00);
		// Inhibited indeterminate weld runs silent until the 5 ms cutoff
		wr(`WC_A_CTRL, 32'h0000_007b);
		wr(`WC_A_CUT, 32'h0000_0005);
		plc.drive(`WC_I_INH, 1, 6'h01);
		plc.drive(`WC_I_XST, 1, 6'h01);
		`CHK({ctl.sonics, ctl.busy}, 2'b01);
		plc.drive(`WC_I_XST, 1, 6'h00);
		`CHK(ctl.busy, 1'b1);
		repeat (45) @(posedge clk_i);
		`CHK(ctl.busy, 1'b0);
		plc.drive(`WC_I_INH, 1, 6'h00);
		// Seek, scan and test last as long as their lines
		foreach (sidx[i]) begin
			plc.drive(sidx[i], 1, 6'h01);
			`CHK({ctl.sonics, ctl.ready, ctl.seek}, i ? 3'b100 : 3'b101);
			plc.drive(sidx[i], 1, 6'h00);
			`CHK(ctl.sonics, 1'b0);
		end
		plc.drive(`WC_I_HOME, 1, 6'h01);
		`CHK(ctl.home, 1'b1);
		plc.drive(`WC_I_RF, 4, 6'h0a);
		plc.drive(`WC_I_RFOK, 1, 6'h01);
		`CHK({ctl.rf_ok, ctl.relay}, 5'h1a);
		wr(`WC_A_CTRL, 32'h0000_0029);
		repeat (3) @(posedge clk_i);
		`CHK(ctl.relay, 4'h2);
		plc.drive(`WC_I_PSEL, 6, 6'h2d);
		plc.drive(`WC_I_PLOAD, 1, 6'h01);
		`CHK(ctl.preset, 6'h2d);
		`CHK(n_pld, 1);
		plc.drive(`WC_I_FCTR, 1, 6'h01);
		`CHK(n_ctr, 1);
		// Inverted polarity turns the held home line inactive
		wr(`WC_A_POL, 32'h0000_0004);
		repeat (12) @(posedge clk_i);
		`CHK(ctl.home, 1'b0);
		wr(`WC_A_POL, 32'h0000_0000);
		plc.glitch(`WC_I_LOCK, 2);
		`CHK(ctl.lock, 1'b0);
		plc.drive(`WC_I_LOCK, 1, 6'h01);
		`CHK(ctl.lock, 1'b1);
		wr(`WC_A_CTRL, 32'h0000_0000);
		rdchk(`WC_A_CTRL, 32'h0000_0029);
		plc.drive(`WC_I_LOCK, 1, 6'h00);
		// Clock enable low freezes the pin pipeline
		ce <= 1'b0;
		plc.drive(`WC_I_LOCK, 1, 6'h01);
		`CHK(ctl.lock, 1'b0);
		ce <= 1'b1;
		repeat (12) @(posedge clk_i);
		`CHK(ctl.lock, 1'b1);
		plc.drive(`WC_I_LOCK, 1, 6'h00);
		// Leaving manual mode silences every function
		wr(`WC_A_CTRL, 32'h0000_0000);
		repeat (8) @(posedge clk_i);
		rdchk(`WC_A_LVL, 32'h0000_0000);
		conclude();
	end
endmodule : tb
